/* File: src/nvm_device.sv */
// Device end: key-protected copy of user memory 0x200-0x3cf to and from a
// SECDED-protected shadow array, with command, result and sticky status registers.
// Assumes a bus master on the same clock obeying the nvm_if timing.
`timescale 1ns/1ps
`include "nvm_params.svh"
// Contract
// - Host writes unlock key before commands
// - Key bytes A5,3C,0F,5A low to high
// - Host writes 0x96 to start load
// - Store copies user memory into shadow array
// - Load restores user memory from shadow
// - Finish raises pin, clears start, sets done
// - Host waits for completion before reading
// - Result code 0x00 pass, 0xff fail
// - Host treats non-zero result as error; the host checks it only after a load, not after a store
// - Status bits checksum, program, uncorrectable, corrected
// - Corrected flag on repaired load word
// - Uncorrectable flag on unrepairable load word
// - Program failure flag on store error
// - Checksum flag on load checksum mismatch
// - Status flags sticky until cleared
// - Writing 0x00 to status clears flags
// - Reset and sleep exit clear flags
// - Host checks program failure after store
// - Each word SECDED protected
// - Whole-array 32-bit checksum verified on load
module nvm_device #(
  parameter int UR_WORDS = `NVM_UR_WORDS
) (
  input wire logic clk,
  input wire logic nrst,
  nvm_if.dev bus,
  input wire logic sleep_exit,
  input wire logic [`NVM_CW_W-1:0] stuck_mask,
  output logic busy
);
  // Hamming(38,32) plus overall parity in bit 0
  function automatic nvm_pkg::cw_t ecc_enc(input logic [31:0] d);
    nvm_pkg::cw_t c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < `NVM_CW_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        c[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 6; b++)
    begin
      for (int p = 1; p < `NVM_CW_W; p++)
      begin
        if (p[b] && p != (1 << b))
          c[1 << b] = c[1 << b] ^ c[p];
      end
    end
    c[0] = ^c[`NVM_CW_W-1:1];
    return c;
  endfunction

  // Single errors are repaired, double errors flagged
  function automatic nvm_pkg::dec_s ecc_dec(input nvm_pkg::cw_t w);
    nvm_pkg::dec_s r;
    logic [5:0] syn;
    logic par;
    int k;
    syn = '0;
    par = ^w;
    r = '0;
    k = 0;
    for (int p = 1; p < `NVM_CW_W; p++)
    begin
      for (int b = 0; b < 6; b++)
      begin
        if (p[b])
          syn[b] = syn[b] ^ w[p];
      end
    end
    if (syn != 6'h00 && par && syn < 6'(`NVM_CW_W))
    begin
      w[syn] = ~w[syn];
      r.ce = 1'b1;
    end
    else if (syn != 6'h00)
      r.ue = 1'b1;
    else if (par)
      r.ce = 1'b1;
    for (int p = 1; p < `NVM_CW_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        r.data[k] = w[p];
        k++;
      end
    end
    return r;
  endfunction

  logic [31:0] uram [UR_WORDS];
  nvm_pkg::cw_t shadow [UR_WORDS+1];
  nvm_pkg::dev_state_e state_q;
  logic [6:0] idx_q;
  logic [31:0] sum_q;
  logic [7:0] cmd_q;
  logic [7:0] key_q [4];
  logic [7:0] result_q;
  logic [3:0] flags_q;
  logic ld_bad_q;
  logic cmplt_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;

  // Address decode for the user window
  wire [9:0] ur_off = bus.addr - `NVM_UR_BASE;
  wire [6:0] ur_idx = ur_off[8:2];
  wire [1:0] ur_lane = ur_off[1:0];
  wire in_ur = bus.addr >= `NVM_UR_BASE && bus.addr <= `NVM_UR_LAST;
  wire idle = state_q == nvm_pkg::S_IDLE;
  wire cmd_wr = bus.wr && bus.addr == `NVM_CMD_OFF && idle;
  wire go = cmd_wr && bus.wdata[`NVM_START_BIT];
  wire key_ok = {key_q[0], key_q[1], key_q[2], key_q[3]} == `NVM_KEY;
  wire last = idx_q == 7'(UR_WORDS);

  // Word under the sequencer: user word or, past the end, the checksum
  wire [31:0] src_word = last ? sum_q : uram[idx_q];
  wire nvm_pkg::cw_t exp_cw = ecc_enc(src_word);
  wire nvm_pkg::dec_s dec = ecc_dec(shadow[idx_q]);
  wire in_ld = state_q == nvm_pkg::S_LD;
  wire set_ce = in_ld && dec.ce;
  wire set_ue = in_ld && dec.ue;
  wire set_ck = in_ld && last && dec.data != sum_q;
  wire set_pf = state_q == nvm_pkg::S_VF && shadow[idx_q] != exp_cw;
  wire [3:0] flag_set = {set_ck, set_pf, set_ue, set_ce};
  wire flag_clr = (bus.wr && bus.addr == `NVM_STAT_OFF && bus.wdata == `NVM_STAT_CLR)
    || sleep_exit;

  // Read selection; unmapped addresses read zero
  always_comb
  begin
    case (bus.addr)
      `NVM_CMD_OFF: rd_mux = cmd_q;
      `NVM_KEY3_OFF: rd_mux = key_q[0];
      `NVM_KEY2_OFF: rd_mux = key_q[1];
      `NVM_KEY1_OFF: rd_mux = key_q[2];
      `NVM_KEY0_OFF: rd_mux = key_q[3];
      `NVM_RES_OFF: rd_mux = result_q;
      `NVM_STAT_OFF: rd_mux = {4'h0, flags_q};
      default: rd_mux = in_ur ? uram[ur_idx][ur_lane*8 +: 8] : 8'h00;
    endcase
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else
      rdata_q <= bus.rd ? rd_mux : 8'h00;
  end

  // Key bytes, written MSB first at the lowest address
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      key_q <= '{default: `NVM_KEY_RST};
    else if (bus.wr && bus.addr >= `NVM_KEY3_OFF && bus.addr <= `NVM_KEY0_OFF)
      key_q[bus.addr[1:0]] <= bus.wdata;
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flags_q <= 4'h0;
    else
      flags_q <= (flag_clr ? 4'h0 : flags_q) | flag_set;
  end

  // User memory: bus writes only while idle so a copy sees a stable image
  always_ff @(posedge clk)
  begin
    if (bus.wr && in_ur && idle)
      uram[ur_idx][ur_lane*8 +: 8] <= bus.wdata;
    else if (in_ld && !last)
      uram[idx_q] <= dec.data;
  end

  // Shadow array; stuck_mask models cells that fail to program
  always_ff @(posedge clk)
  begin
    if (state_q == nvm_pkg::S_ST)
      shadow[idx_q] <= exp_cw ^ stuck_mask;
  end

  // Sequencer: one word per cycle, checksum entry last
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= nvm_pkg::S_IDLE;
      idx_q <= 7'h00;
      sum_q <= 32'h0;
      ld_bad_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        nvm_pkg::S_IDLE:
        begin
          idx_q <= 7'h00;
          sum_q <= 32'h0;
          ld_bad_q <= 1'b0;
          if (go && key_ok && bus.wdata == `NVM_STORE_CMD)
            state_q <= nvm_pkg::S_ST;
          else if (go && key_ok && bus.wdata == `NVM_LOAD_CMD)
            state_q <= nvm_pkg::S_LD;
          else if (go)
            state_q <= nvm_pkg::S_FIN;
        end
        nvm_pkg::S_ST:
        begin
          sum_q <= last ? sum_q : sum_q + uram[idx_q];
          idx_q <= last ? 7'h00 : idx_q + 7'h01;
          if (last)
            state_q <= nvm_pkg::S_VF;
        end
        nvm_pkg::S_VF:
        begin
          idx_q <= idx_q + 7'h01;
          if (last)
            state_q <= nvm_pkg::S_FIN;
        end
        nvm_pkg::S_LD:
        begin
          sum_q <= sum_q + dec.data;
          idx_q <= idx_q + 7'h01;
          ld_bad_q <= ld_bad_q | dec.ue | set_ck;
          if (last)
            state_q <= nvm_pkg::S_FIN;
        end
        nvm_pkg::S_FIN: state_q <= nvm_pkg::S_IDLE;
        default: state_q <= nvm_pkg::S_IDLE;
      endcase
    end
  end

  // Command byte, completion pin and load result
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_q <= `NVM_CMD_RST;
      cmplt_q <= 1'b0;
      result_q <= `NVM_RES_PASS;
    end
    else if (cmd_wr)
    begin
      cmd_q <= bus.wdata;
      cmplt_q <= 1'b0;
    end
    else if (state_q == nvm_pkg::S_FIN)
    begin
      cmd_q[`NVM_START_BIT] <= 1'b0;
      cmd_q[`NVM_DONE_BIT] <= 1'b1;
      cmplt_q <= 1'b1;
      if (cmd_q == `NVM_LOAD_CMD)
        result_q <= (ld_bad_q || !key_ok) ? `NVM_RES_FAIL : `NVM_RES_PASS;
    end
  end

  // Busy covers the whole copy, from the command edge to the pin
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      busy <= 1'b0;
    else
      busy <= !(idle && !go) && state_q != nvm_pkg::S_FIN;
  end

  assign bus.rdata = rdata_q;
  assign bus.cmplt = cmplt_q;
endmodule

/* File: include/nvm_params.svh */
// Constants for the shadow nonvolatile load/store controller.
// Assumes an 8-bit register bus with a 10-bit byte address.
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH
`define NVM_ADDR_W 10
`define NVM_DATA_W 8
`define NVM_CW_W 39
// Register offsets
`define NVM_CMD_OFF 10'h000
`define NVM_KEY3_OFF 10'h0b0
`define NVM_KEY2_OFF 10'h0b1
`define NVM_KEY1_OFF 10'h0b2
`define NVM_KEY0_OFF 10'h0b3
`define NVM_RES_OFF 10'h0d0
`define NVM_STAT_OFF 10'h0f9
// Shadowed user memory window
`define NVM_UR_BASE 10'h200
`define NVM_UR_LAST 10'h3cf
`define NVM_UR_WORDS 116
// Unlock key and command bytes
`define NVM_KEY 32'ha53c0f5a
`define NVM_STORE_CMD 8'h95
`define NVM_LOAD_CMD 8'h96
`define NVM_START_BIT 7
`define NVM_DONE_BIT 6
// Result codes and status bit positions
`define NVM_RES_PASS 8'h00
`define NVM_RES_FAIL 8'hff
`define NVM_STAT_CLR 8'h00
`define NVM_ST_CKS 3
`define NVM_ST_PFAIL 2
`define NVM_ST_UE 1
`define NVM_ST_CE 0
`define NVM_CMD_RST 8'h00
`define NVM_KEY_RST 8'h00
`endif

/* File: include/nvm_pkg.sv */
// Types shared by both ends of the shadow nonvolatile controller.
// Assumes nvm_params.svh is on the include path.
`include "nvm_params.svh"
package nvm_pkg;
  typedef logic [`NVM_CW_W-1:0] cw_t;
  typedef struct packed {
    logic [31:0] data;
    logic ce;
    logic ue;
  } dec_s;
  typedef enum logic [2:0] {S_IDLE, S_ST, S_VF, S_LD, S_FIN} dev_state_e;
  typedef enum logic [2:0] {H_IDLE, H_KEY, H_CMD, H_GAP, H_WAIT, H_RRES, H_RSTAT, H_CAP}
    host_state_e;
endpackage

/* File: include/nvm_if.sv */
// Register bus and completion pin between host controller and device.
// Both ends run on the same clk; no clocking block.
`timescale 1ns/1ps
`include "nvm_params.svh"
interface nvm_if;
  logic [`NVM_ADDR_W-1:0] addr;
  logic [`NVM_DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [`NVM_DATA_W-1:0] rdata;
  logic cmplt;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output cmplt);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input cmplt);
endinterface

/* File: src/nvm_host.sv */
// Host end: unlocks, issues a store or load, waits for the pin, then reads
// back result and status; passes plain user accesses through while idle.
// Assumes the device end on the same clock behind nvm_if.
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_host (
  input wire logic clk,
  input wire logic nrst,
  nvm_if.host bus,
  input wire logic go,
  input wire logic store,
  input wire logic [`NVM_ADDR_W-1:0] usr_addr,
  input wire logic [7:0] usr_wdata,
  input wire logic usr_wr,
  input wire logic usr_rd,
  output logic [7:0] usr_rdata,
  output logic busy,
  output logic done,
  output logic ok,
  output logic [7:0] result,
  output logic [3:0] flags
);
  nvm_pkg::host_state_e state_q;
  logic [1:0] cnt_q;
  logic store_q;
  logic [9:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic rd_q;

  wire [31:0] key = `NVM_KEY;
  wire [7:0] key_byte = key[8*(3-cnt_q) +: 8];
  wire [7:0] cmd_byte = store_q ? `NVM_STORE_CMD : `NVM_LOAD_CMD;

  // Sequence; bus outputs are registered in the state that issues them
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= nvm_pkg::H_IDLE;
      cnt_q <= 2'h0;
      store_q <= 1'b0;
      addr_q <= `NVM_CMD_OFF;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      ok <= 1'b0;
      result <= 8'h00;
      flags <= 4'h0;
    end
    else
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      done <= 1'b0;
      case (state_q)
        nvm_pkg::H_IDLE:
        begin
          cnt_q <= 2'h0;
          if (go)
          begin
            store_q <= store;
            busy <= 1'b1;
            state_q <= nvm_pkg::H_KEY;
          end
          else
          begin
            addr_q <= usr_addr;
            wdata_q <= usr_wdata;
            wr_q <= usr_wr;
            rd_q <= usr_rd;
          end
        end
        nvm_pkg::H_KEY:
        begin
          addr_q <= `NVM_KEY3_OFF + 10'(cnt_q);
          wdata_q <= key_byte;
          wr_q <= 1'b1;
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == 2'h3)
            state_q <= nvm_pkg::H_CMD;
        end
        nvm_pkg::H_CMD:
        begin
          addr_q <= `NVM_CMD_OFF;
          wdata_q <= cmd_byte;
          wr_q <= 1'b1;
          state_q <= nvm_pkg::H_GAP;
        end
        // One cycle so the stale pin from the last command has dropped
        nvm_pkg::H_GAP: state_q <= nvm_pkg::H_WAIT;
        nvm_pkg::H_WAIT:
        begin
          if (bus.cmplt)
            state_q <= nvm_pkg::H_RRES;
        end
        nvm_pkg::H_RRES:
        begin
          addr_q <= `NVM_RES_OFF;
          rd_q <= 1'b1;
          state_q <= nvm_pkg::H_RSTAT;
        end
        nvm_pkg::H_RSTAT:
        begin
          addr_q <= `NVM_STAT_OFF;
          rd_q <= 1'b1;
          state_q <= nvm_pkg::H_CAP;
        end
        nvm_pkg::H_CAP:
        begin
          if (!rd_q)
          begin
            flags <= bus.rdata[3:0];
            ok <= store_q ? !bus.rdata[`NVM_ST_PFAIL] : result == `NVM_RES_PASS;
            done <= 1'b1;
            busy <= 1'b0;
            state_q <= nvm_pkg::H_IDLE;
          end
          else
            result <= bus.rdata;
        end
        default: state_q <= nvm_pkg::H_IDLE;
      endcase
    end
  end

  // Read data of a pass-through read, one cycle behind the bus answer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      usr_rdata <= 8'h00;
    else
      usr_rdata <= bus.rdata;
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
endmodule

/* File: verification/nvm_bus_props.sv */
// Checker for the register bus and completion pin between the two ends.
// Assumes one clock; sees only the interface signals, clock and reset.
`timescale 1ns/1ps
module nvm_bus_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic cmplt
);
  logic [7:0] key_q [4];
  // Decodes; the key copy lets command checks know whether the unlock held
  wire key_hit = addr[9:2] == 8'h2c;
  wire [7:0] key_rd = key_q[addr[1:0]];
  wire key_ok = {key_q[0], key_q[1], key_q[2], key_q[3]} == 32'ha53c0f5a;
  wire cmd_wr = wr && addr == 10'h000 && wdata[7];
  // Shadow copy of the four key bytes as the bus writes them
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      key_q <= '{default: 8'h00};
    end
    else if (wr && key_hit)
    begin
      key_q[addr[1:0]] <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_load_time: assert property (cmd_wr && wdata == 8'h96 && key_ok
    |=> !cmplt [*8] ##[108:112] cmplt) else $error("load finish time wrong");
  a_store_time: assert property (cmd_wr && wdata == 8'h95 && key_ok
    |=> !cmplt [*8] ##[225:229] cmplt) else $error("store finish time wrong");
  a_pin_clears: assert property (cmd_wr |=> !cmplt)
    else $error("pin still high after command write");
  a_done_bits: assert property (rd && addr == 10'h000 && cmplt
    |=> rdata[7:6] == 2'b01) else $error("start and done bits wrong after finish");
  a_result_code: assert property (rd && addr == 10'h0d0
    |=> rdata inside {8'h00, 8'hff}) else $error("result code neither pass nor fail");
  a_stat_upper: assert property (rd && addr == 10'h0f9
    |=> rdata[7:4] == 4'h0) else $error("unused status bits set");
  a_key_back: assert property (rd && key_hit |=> rdata == $past(key_rd))
    else $error("key byte read back wrong");
  a_stat_clear: assert property (wr && addr == 10'h0f9 && wdata == 8'h00 && cmplt
    ##[1:6] (rd && addr == 10'h0f9) |=> rdata[3:0] == 4'h0)
    else $error("status flags survive clear");
endmodule

/* File: verification/shadow_nvm_load_store_control_bench.sv */
// Bench for the host and device ends joined by their interface.
// Drives the host user side and the device fault inputs on one clock.
`timescale 1ns/1ps
module shadow_nvm_load_store_control_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic store = 1'b0;
  logic [9:0] usr_addr = 10'h000;
  logic [7:0] usr_wdata = 8'h00;
  logic usr_wr = 1'b0;
  logic usr_rd = 1'b0;
  logic sleep_exit = 1'b0;
  logic [38:0] stuck_mask = 39'h0;
  logic [7:0] usr_rdata, result;
  logic dev_busy, host_busy, done, ok;
  logic [3:0] flags;
  logic [7:0] key_exp [4] = '{8'ha5, 8'h3c, 8'h0f, 8'h5a};
  int fail_count = 0;
  int total_checks = 0;
  nvm_if bus_if ();
  nvm_device nvm_device_i (.clk(clk), .nrst(nrst), .bus(bus_if.dev),
    .sleep_exit(sleep_exit), .stuck_mask(stuck_mask), .busy(dev_busy));
  nvm_host nvm_host_i (.clk(clk), .nrst(nrst), .bus(bus_if.host), .go(go), .store(store),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd),
    .usr_rdata(usr_rdata), .busy(host_busy), .done(done), .ok(ok), .result(result),
    .flags(flags));
  nvm_bus_props nvm_bus_props_i (.clk(clk), .nrst(nrst), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .cmplt(bus_if.cmplt));
  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic uwr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    usr_addr <= a;
    usr_wdata <= d;
    usr_wr <= 1'b1;
    @(posedge clk);
    usr_wr <= 1'b0;
  endtask
  // Read data stands only in the third cycle after the strobe is raised;
  // it is looked at there alone, so a late or early answer shows up
  task automatic urd(input logic [9:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    usr_addr <= a;
    usr_rd <= 1'b1;
    @(posedge clk);
    usr_rd <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(what, exp, usr_rdata);
  endtask
  // Whole window is written so no unknown word reaches the shadow array
  task automatic fill(input logic [7:0] salt);
    for (int a = 'h200; a <= 'h3cf; a++) uwr(a[9:0], a[7:0] ^ salt);
  endtask
  task automatic cmpmem(input logic [7:0] salt);
    for (int a = 'h200; a <= 'h3cf; a++) urd(a[9:0], a[7:0] ^ salt, "user byte");
  endtask
  task automatic run(input logic st, input logic exp_ok, input logic [7:0] exp_res,
    input logic [3:0] mask, input logic [3:0] exp_fl);
    int n;
    logic seen;
    @(posedge clk);
    go <= 1'b1;
    store <= st;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    seen = 1'b0;
    // Device busy must show at some point while the host waits for the pin
    while (done !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      seen = seen | dev_busy;
      n++;
    end
    if (n >= 1000)
    begin
      fail_count++;
      $display("BAD done expected 1 seen 0");
      summarize();
    end
    else
    begin
      chk("ok", {7'h0, exp_ok}, {7'h0, ok});
      chk("result", exp_res, result);
      chk("flags", {4'h0, exp_fl}, {4'h0, flags & mask});
      chk("busy seen", 8'h01, {7'h0, seen});
      chk("busy at done", 8'h00, {6'h0, host_busy, dev_busy});
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    urd(10'h0d0, 8'h00, "result at reset");
    urd(10'h0f9, 8'h00, "status at reset");
    uwr(10'h3d0, 8'h3c);
    urd(10'h3d0, 8'h00, "unmapped");
    uwr(10'h0b1, 8'h77);
    urd(10'h0b1, 8'h77, "key byte rw");
    $display("test registers finished");
    fill(8'h11);
    run(1'b1, 1'b1, 8'h00, 4'hf, 4'h0);
    urd(10'h000, 8'h55, "command after store");
    for (int i = 0; i < 4; i++) urd(10'h0b0 + i[9:0], key_exp[i], "key byte");
    fill(8'hee);
    run(1'b0, 1'b1, 8'h00, 4'hf, 4'h0);
    cmpmem(8'h11);
    urd(10'h000, 8'h56, "command after load");
    $display("test store load finished");
    @(posedge clk);
    stuck_mask <= 39'h8;
    fill(8'h22);
    run(1'b1, 1'b0, 8'h00, 4'hf, 4'h4);
    @(posedge clk);
    stuck_mask <= 39'h0;
    fill(8'h00);
    run(1'b0, 1'b1, 8'h00, 4'hf, 4'h5);
    cmpmem(8'h22);
    uwr(10'h0f9, 8'h01);
    urd(10'h0f9, 8'h05, "status kept");
    uwr(10'h0f9, 8'h00);
    urd(10'h0f9, 8'h00, "status cleared");
    $display("test corrected finished");
    @(posedge clk);
    stuck_mask <= 39'h220;
    fill(8'h33);
    run(1'b1, 1'b0, 8'h00, 4'hf, 4'h4);
    @(posedge clk);
    stuck_mask <= 39'h0;
    run(1'b0, 1'b0, 8'hff, 4'h6, 4'h6);
    @(posedge clk);
    sleep_exit <= 1'b1;
    @(posedge clk);
    sleep_exit <= 1'b0;
    urd(10'h0f9, 8'h00, "status after sleep");
    fill(8'h44);
    run(1'b1, 1'b1, 8'hff, 4'hf, 4'h0);
    run(1'b0, 1'b1, 8'h00, 4'hf, 4'h0);
    cmpmem(8'h44);
    $display("test uncorrectable finished");
    // A load with a spoiled key must not touch user memory; word 0 would go first
    uwr(10'h200, 8'haa);
    uwr(10'h0b1, 8'h77);
    uwr(10'h000, 8'h96);
    urd(10'h200, 8'haa, "user byte after locked load");
    urd(10'h0d0, 8'hff, "result after locked load");
    urd(10'h000, 8'h56, "command after locked load");
    $display("test locked key finished");
    summarize();
  end
endmodule
